// ==== dv/terminal_module_msg_header_codec_tb.sv ====
// Testbench of the message header codec
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module terminal_module_msg_header_codec_tb;
    logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, rd_q = 1'b0;
    logic [7:0] reg_addr = 8'h00, tag = 8'h00, tgt = 8'h2A;
    logic [31:0] reg_wdata = 32'h0, rs = 32'h6705BBC6, reg_rdata;
    logic rx_valid, rx_first, rx_last, hdr_valid, pay_valid, err_valid, host_may_write, tx_valid, tx_ready, tx_done;
    logic [7:0] rx_data, hdr_kind, hdr_tag, pay_byte, err_code, tx_data, k, b0;
    logic [15:0] hdr_count, cnt;
    logic [2:0] ctl;
    logic [7:0] kinds[4] = '{8'h01, 8'h04, 8'h0A, 8'h22};
    logic [7:0] sam_kinds[10] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0F, 8'h11, 8'h15, 8'h23};
    logic [35:0] expq[$];
    int miscompares = 0, n_compared = 0, n_done = 0;
    always #5 clock = ~clock;
    tmhc_codec dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_first,
        .rx_last, .rx_data, .hdr_valid, .hdr_kind, .hdr_tag, .hdr_count, .pay_valid, .pay_byte, .err_valid,
        .err_code, .host_may_write, .tx_valid, .tx_data, .tx_ready, .tx_done);
    tmhc_host_model host (.clock, .slow, .rx_valid, .rx_first, .rx_last, .rx_data, .tx_ready);
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic push(input logic [3:0] c, input logic [31:0] v);
        expq.push_back({c, v});
    endtask
    task automatic pop(input logic [3:0] c, input logic [31:0] v);
        logic [35:0] e;
        e = (expq.size() > 0) ? expq.pop_front() : 36'hFFFFFFFFF;
        `CHK({c, v}, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        push(4'h5, e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    // One packet: function nibble, optional length and common headers, random body
    task automatic msg(input logic [3:0] fc, input bit ch, input logic [7:0] kind, input logic [15:0] c,
                       input int nb, input int np, input logic [7:0] err);
        logic [7:0] q[$];
        logic [7:0] b;
        logic [15:0] ln;
        ln = c + 16'h0008;
        q = {{fc, 4'h0}};
        if (ch) q = {q, tgt, ln[15:8], ln[7:0], kind, tag, c[15:8], c[7:0]};
        for (int i = 0; i < nb; i++) begin
            b = rnd();
            q.push_back(b);
            if (i < np) push(4'h2, {24'h0, b});
        end
        if (err != 8'h00) push(4'h3, {24'h0, err});
        host.send(q);
    endtask
    task automatic good(input logic [3:0] fc, input logic [7:0] kind, input logic [15:0] c, input int nb);
        tag = rnd();
        push(4'h1, {kind, tag, c});
        msg(fc, 1'b1, kind, c, nb, nb, 8'h00);
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Results appear one cycle after their cause, read data in the cycle after the strobe
    always @(posedge clock) begin
        rd_q <= reg_rd;
        if (rst_n && hdr_valid) pop(4'h1, {hdr_kind, hdr_tag, hdr_count});
        if (rst_n && pay_valid) pop(4'h2, {24'h0, pay_byte});
        if (rst_n && err_valid) pop(4'h3, {24'h0, err_code});
        if (rst_n && tx_valid && tx_ready) pop(4'h4, {24'h0, tx_data});
        if (rd_q) pop(4'h5, reg_rdata);
        if (rst_n && tx_done) n_done++;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        `CHK({hdr_valid, err_valid, tx_valid, host_may_write}, 4'h0)
        rd(8'h0C, 32'h0);
        foreach (kinds[i]) begin
            good(i % 2 ? 4'h6 : 4'h5, kinds[i], 16'h0002, 2);
            `CHK(host_may_write, i % 2 == 1)
        end
        good(4'h1, 8'h01, 16'h0003, 3);
        good(4'h2, 8'h04, 16'h0001, 1);
        push(4'h1, 32'h07000000);
        msg(4'h0, 1'b0, 8'h00, 16'h0, 12, 12, 8'h00);
        push(4'h1, 32'hFF000000);
        msg(4'hD, 1'b0, 8'h00, 16'h0, 4, 4, 8'h00);
        msg(4'h3, 1'b0, 8'h00, 16'h0, 3, 0, 8'h00);
        `CHK(host_may_write, 1'b0)
        msg(4'h4, 1'b0, 8'h00, 16'h0, 3, 0, 8'h00);
        `CHK(host_may_write, 1'b1)
        msg(4'hE, 1'b0, 8'h00, 16'h0, 2, 0, 8'h07);
        msg(4'hF, 1'b0, 8'h00, 16'h0, 2, 0, 8'h07);
        msg(4'h6, 1'b1, 8'h02, 16'h0002, 2, 0, 8'h07);
        good(4'h8, 8'h22, 16'h000A, 3);
        msg(4'hC, 1'b0, 8'h00, 16'h0, 4, 4, 8'h00);
        msg(4'hA, 1'b0, 8'h00, 16'h0, 3, 3, 8'h00);
        `CHK(host_may_write, 1'b1)
        rd(8'h08, {16'h000A, tag, 8'h22});
        msg(4'h9, 1'b0, 8'h00, 16'h0, 2, 0, 8'hFE);
        good(4'h7, 8'h01, 16'h0014, 2);
        msg(4'h6, 1'b1, 8'h01, 16'h0002, 2, 0, 8'hFE);
        tag = rnd();
        push(4'h1, {8'h04, tag, 16'h0001});
        msg(4'h6, 1'b1, 8'h04, 16'h0001, 2, 1, 8'h02);
        push(4'h1, {8'h0A, tag, 16'h0003});
        msg(4'h5, 1'b1, 8'h0A, 16'h0003, 1, 1, 8'h02);
        good(4'h6, 8'h0A, 16'h0001, 1);
        foreach (sam_kinds[i]) begin
            k = sam_kinds[i];
            cnt = {8'h00, rnd()};
            ctl = {rs[9], rs[10], 1'b1};
            slow <= i % 2 == 1;
            b0 = {(k == 8'h08 || k == 8'h09) ? ctl[1] : ctl[2], 4'b0011, 3'h3};
            if (k == 8'h08 || k == 8'h09) b0[2:0] = 3'h0;
            if (k == 8'h02 || k == 8'h03) b0[2:0] = 3'h1;
            if (k == 8'h05 || k == 8'h06) b0[2:0] = 3'h2;
            push(4'h4, {24'h0, b0});
            if (b0[2:0] != 3'h0) begin
                push(4'h4, {24'h0, tgt});
                push(4'h4, {16'h0, cnt + 16'h0008} >> 8);
                push(4'h4, {24'h0, cnt[7:0] + 8'h08});
                push(4'h4, {24'h0, k});
                push(4'h4, {24'h0, tag});
                push(4'h4, {24'h0, cnt[15:8]});
                push(4'h4, {24'h0, cnt[7:0]});
            end
            wr(8'h04, {8'h00, cnt, k});
            wr(8'h00, {29'h0, ctl});
            for (int j = 0; j < 200; j++) begin
                @(negedge clock);
                if (!tx_valid) break;
            end
            `CHK(n_done, i + 1)
        end
        rd(8'h00, {29'h0, ctl[2:1], 1'b0});
        rd(8'h10, 32'h0);
        rd(8'h0C, 32'h00000202);
        repeat (5) @(posedge clock);
        `CHK(expq.size(), 0)
        close_out();
    end
endmodule // terminal_module_msg_header_codec_tb
bind tmhc_codec tmhc_codec_chk chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .rx_valid, .rx_first,
    .rx_data, .hdr_valid, .hdr_kind, .hdr_count, .err_valid, .err_code, .host_may_write, .tx_valid, .tx_data,
    .tx_ready, .tx_done);

// ==== dv/tmhc_codec_chk.sv ====
// Port assertions of the message header codec
`timescale 1ns/1ps
module tmhc_codec_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic [7:0] rx_data,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_kind,
    input wire logic [15:0] hdr_count,
    input wire logic err_valid,
    input wire logic [7:0] err_code,
    input wire logic host_may_write,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic tx_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic sop = rx_valid && rx_first;
    wire logic [3:0] fn = rx_data[7:4];
    AST_RSV_ERR: assert property (sop && fn >= 4'hE |=> err_valid && err_code == 8'h07)
        else $error("reserved function code not flagged");
    AST_ACF_HDR: assert property (sop && fn == 4'h0 |=> hdr_valid && hdr_kind == 8'h07 && hdr_count == 16'h0000)
        else $error("access-code packet header wrong");
    AST_FCNT_HDR: assert property (sop && fn == 4'hD |=> hdr_valid && hdr_kind == 8'hFF)
        else $error("frame count packet kind wrong");
    AST_FLOW: assert property (sop && fn >= 4'h3 && fn <= 4'hC |=> err_valid || host_may_write == !$past(rx_data[4]))
        else $error("transmit permission wrong");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte changed while stalled");
    AST_TX_B0: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] && !tx_valid |=> tx_valid && tx_data[6:3] == 4'b0011)
        else $error("response header byte malformed");
    AST_TX_END: assert property (tx_done |-> tx_valid && tx_ready ##1 !tx_valid)
        else $error("response end wrong");
    AST_HDR_KIND: assert property (hdr_valid |-> hdr_kind inside {8'h01, 8'h04, 8'h0A, 8'h22, 8'h07, 8'hFF})
        else $error("decoded kind not a terminal kind");
    AST_ERR_CODE: assert property (err_valid |-> err_code inside {8'h02, 8'h07, 8'hFE})
        else $error("fault code outside the parser set");
endmodule // tmhc_codec_chk

// ==== dv/tmhc_host_model.sv ====
// Terminal host model: feeds packet bytes and accepts response bytes
`timescale 1ns/1ps
module tmhc_host_model (
    input wire logic clock,
    input wire logic slow,
    output logic rx_valid,
    output logic rx_first,
    output logic rx_last,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    logic [2:0] tick = 3'h0;
    initial begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_last = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // Slow mode stalls the response stream three cycles in four
    always @(posedge clock) begin
        tick <= tick + 3'h1;
        tx_ready <= !slow || tick[1:0] == 2'h3;
    end
    // Byte 0 carries the function nibble; bytes go in order, at most one packet
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge clock);
            rx_valid <= 1'b1;
            rx_first <= i == 0;
            rx_last <= i == b.size() - 1;
            rx_data <= b[i];
        end
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~b[b.size() - 1];
    endtask
endmodule // tmhc_host_model

// ==== include/tmhc_pkg.sv ====
// Types of the message header codec
package tmhc_pkg;
    typedef enum logic [3:0] {
        TMHC_F_AC = 4'h0, TMHC_F_BA = 4'h1, TMHC_F_BR = 4'h2, TMHC_F_NULL0 = 4'h3,
        TMHC_F_NULL1 = 4'h4, TMHC_F_FL0 = 4'h5, TMHC_F_FL1 = 4'h6, TMHC_F_F0 = 4'h7,
        TMHC_F_F1 = 4'h8, TMHC_F_L0 = 4'h9, TMHC_F_L1 = 4'hA, TMHC_F_M0 = 4'hB,
        TMHC_F_M1 = 4'hC, TMHC_F_FCNT = 4'hD, TMHC_F_RSV0 = 4'hE, TMHC_F_RSV1 = 4'hF
    } tmhc_func_t;
    typedef enum logic [2:0] {
        TMHC_RX_IDLE = 3'b000, TMHC_RX_LEN = 3'b001, TMHC_RX_CH = 3'b010,
        TMHC_RX_BODY = 3'b011, TMHC_RX_DROP = 3'b100
    } tmhc_rx_st_t;
    typedef enum logic [1:0] {
        TMHC_TX_IDLE = 2'b00, TMHC_TX_SEND = 2'b01
    } tmhc_tx_st_t;
    typedef struct packed {
        tmhc_rx_st_t rx_st;
        logic [6:0] idx;
        logic [1:0] sub;
        logic in_msg;
        logic seg_end;
        logic chk;
        logic [15:0] remain;
        logic [7:0] target;
        logic [7:0] kind;
        logic [7:0] tag;
        logic [15:0] count;
        logic flow_ok;
        logic hdr_valid;
        logic pay_valid;
        logic [7:0] pay_byte;
        logic err_valid;
        logic [7:0] err_code;
        tmhc_tx_st_t tx_st;
        logic [2:0] tx_idx;
        logic [7:0] tx_byte;
        logic [7:0] tx_kind;
        logic [15:0] tx_count;
        logic acf_pass;
        logic rx_ready;
        logic [31:0] rdata;
    } tmhc_state_t;
endpackage

// ==== include/tmhc_regs.svh ====
// Register map, field positions and protocol codes of the message header codec
`ifndef TMHC_REGS_SVH
`define TMHC_REGS_SVH
`define TMHC_ADDR_CTRL 8'h00
`define TMHC_ADDR_TXMSG 8'h04
`define TMHC_ADDR_RXHDR 8'h08
`define TMHC_ADDR_STAT 8'h0C
`define TMHC_CTRL_GO 0
`define TMHC_CTRL_PASS 1
`define TMHC_CTRL_READY 2
`define TMHC_PKT_BYTES 7'h40
`define TMHC_L1_EXTRA 16'h0008
`define TMHC_TARGET_RST 8'h00
// Message kinds
`define TMHC_K_BA_IND 8'h01
`define TMHC_K_BA_RSP 8'h02
`define TMHC_K_BA_FAIL 8'h03
`define TMHC_K_BR_IND 8'h04
`define TMHC_K_BR_RSP 8'h05
`define TMHC_K_BR_FAIL 8'h06
`define TMHC_K_AC_IND 8'h07
`define TMHC_K_AC_RSP 8'h08
`define TMHC_K_AC_FAIL 8'h09
`define TMHC_K_AC_FCNT 8'hFF
`define TMHC_K_REG_IND 8'h0A
`define TMHC_K_REG_DONE 8'h0F
`define TMHC_K_REG_BOFF 8'h11
`define TMHC_K_DEREG 8'h15
`define TMHC_K_HC_IND 8'h22
`define TMHC_K_HC_RSP 8'h23
// Fault codes detected by the parser
`define TMHC_E_NONE 8'h00
`define TMHC_E_CORRUPT 8'h02
`define TMHC_E_INVALID 8'h07
`define TMHC_E_SEQ 8'hFE
// Module-to-terminal header fields
`define TMHC_M_FUNC_AC 3'h0
`define TMHC_M_FUNC_BA 3'h1
`define TMHC_M_FUNC_BR 3'h2
`define TMHC_M_FUNC_DATA 3'h3
`define TMHC_M_FL_SINGLE 2'h3
`endif

// ==== rtl/tmhc_codec.sv ====
// Message header codec of the security module: terminal packet parser and response header builder
`timescale 1ns/1ps
`include "tmhc_regs.svh"
module tmhc_codec import tmhc_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic rx_last,
    input wire logic [7:0] rx_data,
    output logic hdr_valid,
    output logic [7:0] hdr_kind,
    output logic [7:0] hdr_tag,
    output logic [15:0] hdr_count,
    output logic pay_valid,
    output logic [7:0] pay_byte,
    output logic err_valid,
    output logic [7:0] err_code,
    output logic host_may_write,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic tx_done
);
    tmhc_state_t st_ff;
    tmhc_state_t nxt_st;

    // Transmit-FIFO permission carried by a terminal function code
    function automatic logic func_permits(input logic [3:0] f);
        return (f == TMHC_F_NULL1) || (f == TMHC_F_FL1) || (f == TMHC_F_F1) ||
               (f == TMHC_F_L1) || (f == TMHC_F_M1);
    endfunction

    function automatic logic func_carries_flow(input logic [3:0] f);
        return (f >= 4'h3) && (f <= 4'hC);
    endfunction

    // Kinds that a terminal may send with the common header
    function automatic logic kind_from_terminal(input logic [7:0] k);
        return (k == `TMHC_K_BA_IND) || (k == `TMHC_K_BR_IND) ||
               (k == `TMHC_K_REG_IND) || (k == `TMHC_K_HC_IND);
    endfunction

    // Access-code kinds travel without the common header
    function automatic logic kind_is_acf(input logic [7:0] k);
        return (k == `TMHC_K_AC_RSP) || (k == `TMHC_K_AC_FAIL);
    endfunction

    function automatic logic [2:0] kind_m2t_func(input logic [7:0] k);
        logic [2:0] f;
        f = `TMHC_M_FUNC_DATA;
        if (kind_is_acf(k)) begin
            f = `TMHC_M_FUNC_AC;
        end else if ((k == `TMHC_K_BA_RSP) || (k == `TMHC_K_BA_FAIL)) begin
            f = `TMHC_M_FUNC_BA;
        end else if ((k == `TMHC_K_BR_RSP) || (k == `TMHC_K_BR_FAIL)) begin
            f = `TMHC_M_FUNC_BR;
        end
        return f;
    endfunction

    function automatic tmhc_state_t raise_err(input tmhc_state_t s, input logic [7:0] code);
        tmhc_state_t r;
        r = s;
        r.err_valid = 1'b1;
        r.err_code = code;
        r.rx_st = TMHC_RX_DROP;
        r.in_msg = 1'b0;
        return r;
    endfunction

    logic [3:0] fn;
    logic [15:0] l1_len;
    logic [7:0] h2_m2t;
    logic c_bit;

    always_comb begin
        nxt_st = st_ff;
        fn = rx_data[7:4];
        nxt_st.hdr_valid = 1'b0;
        nxt_st.pay_valid = 1'b0;
        nxt_st.err_valid = 1'b0;
        // Receive side
        if (rx_valid) begin
            nxt_st.idx = st_ff.idx + 7'h01;
            if (rx_first) begin
                nxt_st.idx = 7'h01;
                nxt_st.sub = 2'h0;
                nxt_st.chk = 1'b0;
                if (func_carries_flow(fn)) begin
                    nxt_st.flow_ok = func_permits(fn);
                end
                case (fn)
                    TMHC_F_RSV0, TMHC_F_RSV1: begin
                        nxt_st = raise_err(nxt_st, `TMHC_E_INVALID);
                    end
                    TMHC_F_NULL0, TMHC_F_NULL1: begin
                        nxt_st.rx_st = TMHC_RX_DROP;
                    end
                    TMHC_F_AC, TMHC_F_FCNT: begin
                        // Access-code packets have neither length header nor common header
                        nxt_st.kind = (fn == TMHC_F_AC) ? `TMHC_K_AC_IND : `TMHC_K_AC_FCNT;
                        nxt_st.tag = 8'h00;
                        nxt_st.count = 16'h0000;
                        nxt_st.hdr_valid = 1'b1;
                        nxt_st.in_msg = 1'b0;
                        nxt_st.rx_st = TMHC_RX_BODY;
                    end
                    TMHC_F_L0, TMHC_F_L1, TMHC_F_M0, TMHC_F_M1: begin
                        if (!st_ff.in_msg) begin
                            nxt_st = raise_err(nxt_st, `TMHC_E_SEQ);
                        end else begin
                            nxt_st.chk = 1'b1;
                            nxt_st.seg_end = (fn == TMHC_F_L0) || (fn == TMHC_F_L1);
                            nxt_st.rx_st = TMHC_RX_BODY;
                        end
                    end
                    default: begin
                        // Opening packet: BA, BR, single, or first segment
                        if (st_ff.in_msg) begin
                            nxt_st = raise_err(nxt_st, `TMHC_E_SEQ);
                        end else begin
                            nxt_st.seg_end = (fn != TMHC_F_F0) && (fn != TMHC_F_F1);
                            nxt_st.rx_st = TMHC_RX_LEN;
                        end
                    end
                endcase
            end else if (st_ff.idx >= `TMHC_PKT_BYTES) begin
                nxt_st = raise_err(nxt_st, `TMHC_E_CORRUPT);
            end else begin
                case (st_ff.rx_st)
                    TMHC_RX_LEN: begin
                        // Length/target bytes are consumed; the common header gives the count
                        nxt_st.sub = st_ff.sub + 2'h1;
                        if (st_ff.sub == 2'h0) begin
                            nxt_st.target = rx_data;
                        end
                        if (st_ff.sub == 2'h2) begin
                            nxt_st.sub = 2'h0;
                            nxt_st.rx_st = TMHC_RX_CH;
                        end
                    end
                    TMHC_RX_CH: begin
                        nxt_st.sub = st_ff.sub + 2'h1;
                        case (st_ff.sub)
                            2'h0: nxt_st.kind = rx_data;
                            2'h1: nxt_st.tag = rx_data;
                            2'h2: nxt_st.count[15:8] = rx_data;
                            default: begin
                                nxt_st.count[7:0] = rx_data;
                                nxt_st.remain = {st_ff.count[15:8], rx_data};
                                nxt_st.chk = 1'b1;
                                if (kind_from_terminal(st_ff.kind)) begin
                                    nxt_st.hdr_valid = 1'b1;
                                    nxt_st.in_msg = 1'b1;
                                    nxt_st.rx_st = TMHC_RX_BODY;
                                end else begin
                                    nxt_st = raise_err(nxt_st, `TMHC_E_INVALID);
                                end
                            end
                        endcase
                    end
                    TMHC_RX_BODY: begin
                        nxt_st.pay_valid = 1'b1;
                        nxt_st.pay_byte = rx_data;
                        if (st_ff.chk) begin
                            if (st_ff.remain == 16'h0000) begin
                                nxt_st = raise_err(nxt_st, `TMHC_E_CORRUPT);
                                nxt_st.pay_valid = 1'b0;
                            end else begin
                                nxt_st.remain = st_ff.remain - 16'h0001;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Packet end: a closing packet must have delivered exactly the counted bytes
            if (rx_last && !nxt_st.err_valid) begin
                if ((nxt_st.rx_st == TMHC_RX_LEN) || (nxt_st.rx_st == TMHC_RX_CH)) begin
                    nxt_st = raise_err(nxt_st, `TMHC_E_CORRUPT);
                end else if (nxt_st.rx_st == TMHC_RX_BODY && nxt_st.chk && nxt_st.seg_end) begin
                    nxt_st.in_msg = 1'b0;
                    if (nxt_st.remain != 16'h0000) begin
                        nxt_st = raise_err(nxt_st, `TMHC_E_CORRUPT);
                    end
                end
                nxt_st.rx_st = TMHC_RX_IDLE;
            end
        end
        // Response header builder
        c_bit = kind_is_acf(st_ff.tx_kind) ? st_ff.acf_pass : st_ff.rx_ready;
        h2_m2t = {c_bit, 2'b00, `TMHC_M_FL_SINGLE, kind_m2t_func(st_ff.tx_kind)};
        l1_len = st_ff.tx_count + `TMHC_L1_EXTRA;
        case (st_ff.tx_st)
            TMHC_TX_SEND: begin
                if (tx_ready) begin
                    nxt_st.tx_idx = st_ff.tx_idx + 3'h1;
                    case (st_ff.tx_idx)
                        3'h0: nxt_st.tx_byte = st_ff.target;
                        3'h1: nxt_st.tx_byte = l1_len[15:8];
                        3'h2: nxt_st.tx_byte = l1_len[7:0];
                        3'h3: nxt_st.tx_byte = st_ff.tx_kind;
                        3'h4: nxt_st.tx_byte = st_ff.tag;
                        3'h5: nxt_st.tx_byte = st_ff.tx_count[15:8];
                        3'h6: nxt_st.tx_byte = st_ff.tx_count[7:0];
                        default: nxt_st.tx_byte = 8'h00;
                    endcase
                    if (kind_is_acf(st_ff.tx_kind) || (st_ff.tx_idx == 3'h7)) begin
                        nxt_st.tx_st = TMHC_TX_IDLE;
                    end
                end
            end
            default: begin
                if (reg_wr && (reg_addr == `TMHC_ADDR_CTRL) && reg_wdata[`TMHC_CTRL_GO]) begin
                    nxt_st.tx_st = TMHC_TX_SEND;
                    nxt_st.tx_idx = 3'h0;
                    nxt_st.tx_byte = {reg_wdata[`TMHC_CTRL_PASS] || reg_wdata[`TMHC_CTRL_READY], 7'h00};
                end
            end
        endcase
        if (st_ff.tx_st == TMHC_TX_IDLE && nxt_st.tx_st == TMHC_TX_SEND) begin
            nxt_st.acf_pass = reg_wdata[`TMHC_CTRL_PASS];
            nxt_st.rx_ready = reg_wdata[`TMHC_CTRL_READY];
            c_bit = kind_is_acf(st_ff.tx_kind) ? reg_wdata[`TMHC_CTRL_PASS] : reg_wdata[`TMHC_CTRL_READY];
            nxt_st.tx_byte = {c_bit, h2_m2t[6:0]};
        end
        // Register writes
        if (reg_wr && (reg_addr == `TMHC_ADDR_TXMSG) && (st_ff.tx_st == TMHC_TX_IDLE)) begin
            nxt_st.tx_kind = reg_wdata[7:0];
            nxt_st.tx_count = reg_wdata[23:8];
        end
        // Register reads, answered in the following cycle
        nxt_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `TMHC_ADDR_CTRL: nxt_st.rdata = {29'h0, st_ff.rx_ready, st_ff.acf_pass, 1'b0};
                `TMHC_ADDR_TXMSG: nxt_st.rdata = {8'h00, st_ff.tx_count, st_ff.tx_kind};
                `TMHC_ADDR_RXHDR: nxt_st.rdata = {st_ff.count, st_ff.tag, st_ff.kind};
                `TMHC_ADDR_STAT: nxt_st.rdata = {21'h0, st_ff.in_msg, st_ff.flow_ok,
                                                 st_ff.tx_st == TMHC_TX_SEND, st_ff.err_code};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.rx_st <= TMHC_RX_IDLE;
            st_ff.tx_st <= TMHC_TX_IDLE;
            st_ff.target <= `TMHC_TARGET_RST;
            st_ff.err_code <= `TMHC_E_NONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign hdr_valid = st_ff.hdr_valid;
    assign hdr_kind = st_ff.kind;
    assign hdr_tag = st_ff.tag;
    assign hdr_count = st_ff.count;
    assign pay_valid = st_ff.pay_valid;
    assign pay_byte = st_ff.pay_byte;
    assign err_valid = st_ff.err_valid;
    assign err_code = st_ff.err_code;
    assign host_may_write = st_ff.flow_ok;
    assign tx_valid = (st_ff.tx_st == TMHC_TX_SEND);
    assign tx_data = st_ff.tx_byte;
    assign tx_done = tx_valid && tx_ready && (kind_is_acf(st_ff.tx_kind) || (st_ff.tx_idx == 3'h7));
endmodule // tmhc_codec
